// ### src/smbus_ctrl_flags.sv
/*
 * Control/status flag logic of the second two-wire serial bus port.
 * Holds the eight-bit control/status register and the hardware
 * acknowledge enable, detects START/STOP on the synchronised pins and
 * holds the clock line low while an interrupt is pending.
 * Assumes a shift engine on CLK_SYS that supplies the eng_ev_s bundle and
 * an external pad that resolves the clock line from SCL_OUT/SCL_OE.
 */
// Overview of operation
// RL1 - Master indicator set on generated START, cleared on STOP generated or arbitration lost.
// RL2 - Transmit indicator set on own START or prior data write; cleared otherwise.
// RL3 - Start flag set when START plus address byte received; only software clears it.
// RL4 - Writing 1 to start flag as master requests START or repeated START.
// RL5 - Writing 1 to stop flag as master schedules STOP; cleared when STOP generated.
// RL6 - Stop flag set on STOP seen as addressed slave or arbitration lost by STOP.
// RL7 - Acknowledge request set on received byte without hardware acknowledge; cleared after ack.
// RL8 - Arbitration lost on unrequested repeated START while master and start flag low.
// RL9 - Arbitration lost when clock sensed low while generating STOP or repeated START.
// RL10 - Arbitration lost when data low while driving 1; cleared when interrupt cleared.
// RL11 - Acknowledge bit captures incoming acknowledge; written value is sent when receiving.
// RL12 - Interrupt set on START generated, arbitration lost, byte sent with ack.
// RL13 - Interrupt set on byte received, address after START, and STOP received.
// RL14 - While interrupt pending the clock line is held low and bus stalls.
// RL15 - Writing 0 clears interrupt and advances engine; writing 1 forces interrupt.
// RL16 - Control register sits bit-addressable at 0xC0 on page F.
// RL17 - With hardware acknowledge on, acknowledge bit is driven on received bytes.
// RL18 - After a refused address, slave events are ignored until next START.
// RL19 - Hardware acknowledge enable is bit 0 of address mask register.
// RL20 - Hardware event beats a software write to the same flag.
`default_nettype none

module smbus_ctrl_flags (
    // Clock, reset and enable.
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    // Special function register port.
    input wire logic [7:0] SFR_ADDR,
    input wire logic [3:0] SFR_PAGE,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_BIT_WR,
    input wire logic [7:0] SFR_BIT_ADDR,
    input wire logic SFR_BIT_VAL,
    output logic [7:0] SFR_RDATA,
    // Data register write strobe and master configuration.
    input wire logic DAT_WR,
    input wire logic MASTER_CFG,
    // Shift engine side.
    input wire smbus_flags_pkg::eng_ev_s ENG_EV,
    output logic START_REQ,
    output logic STOP_PEND,
    output logic GO,
    output logic ACK_OUT,
    output logic ACK_AUTO,
    // Bus pins.
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic SDA_IN
);

    // Register state.
    logic master_q, txmode_q, sta_q, sto_q, ackrq_q, arb_q, ack_q, si_q;
    logic [7:0] adm_q;
    logic dat_written_q, start_seen_q, addressed_q, ignore_q;
    logic [7:0] rdata_q;
    logic start_req_q, go_q;
    logic [smbus_flags_pkg::SYNC_STAGES-1:0] sync_q [2];
    logic stable_q [2], stable_d1_q [2];

    // Write mask for one register: byte write marks all bits, bit write one.
    function automatic logic [7:0] wr_bits(input logic [7:0] reg_addr, input logic bit_able);
        logic [7:0] m;
        m = 8'h00;
        if (SFR_WR && SFR_ADDR == reg_addr && SFR_PAGE == smbus_flags_pkg::REG_PAGE) begin
            m = 8'hFF;
        end
        if (bit_able && SFR_BIT_WR && SFR_BIT_ADDR[7:3] == reg_addr[7:3]
            && SFR_PAGE == smbus_flags_pkg::REG_PAGE) begin
            m[SFR_BIT_ADDR[2:0]] = 1'b1;
        end
        return m;
    endfunction : wr_bits

    // Written value: byte data, or the single bit value on every lane.
    logic [7:0] wval;
    logic [7:0] ctl_we, adm_we;
    always_comb begin
        wval = SFR_WR ? SFR_WDATA : {8{SFR_BIT_VAL}};
        ctl_we = wr_bits(smbus_flags_pkg::CTL_ADDR, 1'b1) & smbus_flags_pkg::CTL_WR_MASK; // RL16
        adm_we = wr_bits(smbus_flags_pkg::ADM_ADDR, 1'b0);
    end

    // Pin synchronisers; a level counts once stages two and three agree.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS or negedge RST_N) begin
                if (!RST_N) begin
                    sync_q[gi] <= '1;
                    stable_q[gi] <= 1'b1;
                    stable_d1_q[gi] <= 1'b1;
                end else if (CE) begin
                    sync_q[gi] <= {sync_q[gi][smbus_flags_pkg::SYNC_STAGES-2:0], (gi == 0) ? SCL_IN : SDA_IN};
                    if (sync_q[gi][1] == sync_q[gi][2]) begin
                        stable_q[gi] <= sync_q[gi][2];
                    end
                    stable_d1_q[gi] <= stable_q[gi];
                end
            end
        end
    endgenerate

    // Bus conditions derived from the stable levels; index 0 clock, 1 data.
    logic scl_s, start_det, stop_det, scl_rise;
    always_comb begin
        scl_s = stable_q[0];
        start_det = scl_s && stable_d1_q[0] && stable_d1_q[1] && !stable_q[1];
        stop_det = scl_s && stable_d1_q[0] && !stable_d1_q[1] && stable_q[1];
        scl_rise = scl_s && !stable_d1_q[0];
    end

    // Arbitration loss causes. An own condition is excused while the engine generates it.
    logic arb_rstart, arb_scl, arb_sda, arb_stop, arb_any;
    always_comb begin
        arb_rstart = start_det && master_q && !sta_q && !ENG_EV.gen_attempt; // RL8
        arb_scl = ENG_EV.gen_attempt && ENG_EV.scl_released && !scl_s; // RL9
        arb_sda = scl_rise && ENG_EV.tx_bit_drive && ENG_EV.tx_bit_val && !stable_q[1]; // RL10
        arb_stop = stop_det && master_q && !ENG_EV.gen_attempt;
        arb_any = arb_rstart || arb_scl || arb_sda || arb_stop;
    end

    // Slave events are suppressed while a refused address is outstanding.
    logic slave_ok;
    assign slave_ok = master_q || !ignore_q; // RL18

    // Software clears the interrupt by writing 0.
    logic si_clr;
    assign si_clr = ctl_we[smbus_flags_pkg::BIT_SI] && !wval[smbus_flags_pkg::BIT_SI];

    // Frame tracking: pending data write, START seen, addressed, ignore window.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dat_written_q <= 1'b0;
            start_seen_q <= 1'b0;
            addressed_q <= 1'b0;
            ignore_q <= 1'b0;
        end else if (CE) begin
            if (ENG_EV.frame_start) begin
                dat_written_q <= 1'b0;
            end
            if (DAT_WR && !ENG_EV.frame_start) begin
                dat_written_q <= 1'b1;
            end
            if (ENG_EV.addr_rx) begin
                start_seen_q <= 1'b0;
            end
            if (start_det) begin
                start_seen_q <= 1'b1;
            end
            if (ENG_EV.addr_rx && !master_q && !ENG_EV.addr_nack && slave_ok) begin
                addressed_q <= 1'b1;
            end
            if (start_det || stop_det) begin
                addressed_q <= 1'b0;
            end
            if (ENG_EV.addr_nack && !master_q) begin
                ignore_q <= 1'b1; // RL18
            end
            if (start_det) begin
                ignore_q <= 1'b0; // RL18
            end
        end
    end

    // Master and transmit indicators; neither is writable.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            master_q <= 1'b0;
            txmode_q <= 1'b0;
        end else if (CE) begin
            if (ENG_EV.stop_gen || arb_any) begin
                master_q <= 1'b0; // RL1
            end else if (ENG_EV.start_gen) begin
                master_q <= 1'b1; // RL1
            end
            if (start_det && !ENG_EV.gen_attempt) begin
                txmode_q <= 1'b0; // RL2
            end
            if (ENG_EV.frame_start) begin
                txmode_q <= dat_written_q || DAT_WR; // RL2
            end
            if (ENG_EV.start_gen) begin
                txmode_q <= 1'b1; // RL2
            end
            if (arb_any) begin
                txmode_q <= 1'b0; // RL2
            end
        end
    end

    // Start and stop flags: software write first, hardware after so it wins.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sta_q <= 1'b0;
            sto_q <= 1'b0;
        end else if (CE) begin
            if (ctl_we[smbus_flags_pkg::BIT_START]) begin
                sta_q <= wval[smbus_flags_pkg::BIT_START];
            end
            if (ENG_EV.addr_rx && !ENG_EV.addr_nack && start_seen_q && slave_ok) begin
                sta_q <= 1'b1; // RL3 RL20
            end
            if (ctl_we[smbus_flags_pkg::BIT_STOP]) begin
                sto_q <= wval[smbus_flags_pkg::BIT_STOP] && master_q; // RL5
            end
            if (ENG_EV.stop_gen) begin
                sto_q <= 1'b0; // RL5
            end
            if ((stop_det && addressed_q && !master_q) || arb_stop) begin
                sto_q <= 1'b1; // RL6 RL20
            end
        end
    end

    // Acknowledge request and acknowledge value.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ackrq_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (CE) begin
            if (ENG_EV.ack_done) begin
                ackrq_q <= 1'b0; // RL7
            end
            if (ENG_EV.byte_rx && !adm_q[smbus_flags_pkg::BIT_HWACK] && slave_ok) begin
                ackrq_q <= 1'b1; // RL7
            end
            if (ctl_we[smbus_flags_pkg::BIT_ACK]) begin
                ack_q <= wval[smbus_flags_pkg::BIT_ACK]; // RL11
            end
            if (ENG_EV.ack_sample && txmode_q) begin
                ack_q <= !stable_q[1]; // RL11 RL20
            end
        end
    end

    // Arbitration lost: cleared with the interrupt, a new loss wins the clear.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            arb_q <= 1'b0;
        end else if (CE) begin
            if (si_clr) begin
                arb_q <= 1'b0; // RL10
            end
            if (arb_any) begin
                arb_q <= 1'b1; // RL8 RL9 RL10 RL20
            end
        end
    end

    // Interrupt flag; a hardware event in the clearing cycle keeps it set.
    logic si_hw;
    always_comb begin
        si_hw = ENG_EV.start_gen || arb_any || ENG_EV.byte_tx_ack; // RL12
        if (slave_ok && (ENG_EV.byte_rx || (ENG_EV.addr_rx && !ENG_EV.addr_nack))) begin
            si_hw = 1'b1; // RL13
        end
        if (stop_det && addressed_q && !master_q) begin
            si_hw = 1'b1; // RL13
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            si_q <= 1'b0;
            go_q <= 1'b0;
        end else if (CE) begin
            if (ctl_we[smbus_flags_pkg::BIT_SI]) begin
                si_q <= wval[smbus_flags_pkg::BIT_SI]; // RL15
            end
            if (si_hw) begin
                si_q <= 1'b1; // RL12 RL13 RL20
            end
            go_q <= si_clr && !si_hw; // RL15
        end
    end

    // Address mask register; only the hardware acknowledge enable is used here.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            adm_q <= smbus_flags_pkg::ADM_RESET;
        end else if (CE) begin
            for (int i = 0; i < 8; i++) begin
                if (adm_we[i]) begin
                    adm_q[i] <= wval[i]; // RL19
                end
            end
        end
    end

    // Start request pulse: only a master configuration may ask for a START.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            start_req_q <= 1'b0;
        end else if (CE) begin
            start_req_q <= ctl_we[smbus_flags_pkg::BIT_START] && wval[smbus_flags_pkg::BIT_START]
                && MASTER_CFG; // RL4
        end
    end

    // Read data registered from the current address; unmapped reads give zero.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= smbus_flags_pkg::CTL_RESET;
        end else if (CE) begin
            rdata_q <= 8'h00;
            if (SFR_PAGE == smbus_flags_pkg::REG_PAGE && SFR_ADDR == smbus_flags_pkg::CTL_ADDR) begin
                rdata_q <= {master_q, txmode_q, sta_q, sto_q, ackrq_q, arb_q, ack_q, si_q};
            end
            if (SFR_PAGE == smbus_flags_pkg::REG_PAGE && SFR_ADDR == smbus_flags_pkg::ADM_ADDR) begin
                rdata_q <= adm_q;
            end
        end
    end

    // Outputs; the clock hold follows the interrupt flag in the same cycle.
    assign SFR_RDATA = rdata_q;
    assign START_REQ = start_req_q;
    assign STOP_PEND = sto_q && master_q; // RL5
    assign GO = go_q;
    assign ACK_OUT = ack_q; // RL17
    assign ACK_AUTO = adm_q[smbus_flags_pkg::BIT_HWACK] && !txmode_q; // RL17
    assign SCL_OE = si_q; // RL14
    assign SCL_OUT = 1'b0;

    // Checks on the flag behaviour.
    AST_SI_HOLDS_SCL: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL14
        si_q |-> SCL_OE && !SCL_OUT) else $error("clock not held while interrupt pending");
    AST_MASTER_ON_START: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL1
        CE && ENG_EV.start_gen && !ENG_EV.stop_gen && !arb_any |=> master_q) else $error("master not set");
    AST_MASTER_OFF_ARB: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL1
        CE && arb_any |=> !master_q && !txmode_q && arb_q && si_q) else $error("arbitration loss effects missing");
    AST_STO_CLR: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL5
        CE && ENG_EV.stop_gen && !stop_det |=> !sto_q) else $error("stop flag not cleared");
    AST_ACKRQ_HW: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL7
        adm_q[smbus_flags_pkg::BIT_HWACK] && !ackrq_q && CE |=> !ackrq_q) else $error("ack request with hw ack");
    AST_ARB_CLR: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL10
        CE && si_clr && !arb_any |=> !arb_q) else $error("arbitration flag not cleared");
    AST_SI_SET_WINS: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL20
        CE && si_clr && si_hw |=> si_q && !GO) else $error("interrupt lost to clear");
    AST_GO_PULSE: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL15
        CE && si_clr && !si_hw |=> GO && !si_q ##1 (!GO || !CE || $past(si_clr)))
        else $error("advance pulse wrong");
    AST_START_REQ: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL4
        START_REQ |-> $past(MASTER_CFG) && sta_q) else $error("start request without master config");
    AST_ACK_CAPTURE: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL11
        CE && ENG_EV.ack_sample && txmode_q |=> ack_q == !$past(stable_q[1])) else $error("ack not captured");
    AST_IGNORE: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL18
        CE && ignore_q && !master_q && !start_det && ENG_EV.byte_rx && !ENG_EV.byte_tx_ack && !arb_any
        && !ENG_EV.start_gen && !si_q && !stop_det && !ctl_we[smbus_flags_pkg::BIT_SI] |=> !si_q)
        else $error("interrupt raised while ignoring");

endmodule : smbus_ctrl_flags

`default_nettype wire

// ### src/smbus_flags_pkg.sv
/*
 * Shared constants and types for the bus control/status flag block:
 * register locations, bit positions, reset values and the event bundle
 * that the shift engine hands to the flag logic.
 * Assumes a single system clock shared by the engine and the flag block.
 */
`default_nettype none

package smbus_flags_pkg;

    // Register locations on the special function register port.
    localparam logic [7:0] CTL_ADDR = 8'hC0;
    localparam logic [7:0] ADM_ADDR = 8'hCE;
    localparam logic [3:0] REG_PAGE = 4'hF;
    localparam logic [4:0] CTL_BIT_BASE = 5'h18;

    // Bit positions of the control/status register.
    localparam int BIT_MASTER = 7;
    localparam int BIT_TXMODE = 6;
    localparam int BIT_START = 5;
    localparam int BIT_STOP = 4;
    localparam int BIT_ACKRQ = 3;
    localparam int BIT_ARBLOST = 2;
    localparam int BIT_ACK = 1;
    localparam int BIT_SI = 0;

    // Hardware acknowledge enable in the address mask register.
    localparam int BIT_HWACK = 0;

    // Reset values.
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] ADM_RESET = 8'hFE;

    // Software may only write these control bits.
    localparam logic [7:0] CTL_WR_MASK = 8'h33;

    // Pin synchroniser depth.
    localparam int SYNC_STAGES = 3;

    // One-cycle events and levels supplied by the shift engine.
    typedef struct packed {
        logic start_gen;    // Engine has driven a START onto the wire.
        logic stop_gen;     // Engine has driven a STOP onto the wire.
        logic frame_start;  // First byte of a frame begins.
        logic addr_rx;      // Address byte plus direction bit received.
        logic byte_rx;      // Data byte received.
        logic byte_tx_ack;  // Byte sent and acknowledge sampled.
        logic ack_sample;   // Acknowledge bit sampled on the wire.
        logic ack_done;     // Acknowledge cycle finished.
        logic addr_nack;    // Hardware refused the received address.
        logic gen_attempt;  // Level: engine generating STOP or repeated START.
        logic scl_released; // Level: engine lets the clock line float.
        logic tx_bit_drive; // Level: engine drives a data bit (not acknowledge).
        logic tx_bit_val;   // Level: value of that data bit.
    } eng_ev_s;

endpackage : smbus_flags_pkg

`default_nettype wire

// ### test/smbus_bus_peer.sv
/*
 * Behavioural model of the other parties on the two-wire bus: a foreign
 * master that frames START, data bits and STOP with a 48 ns bit clock.
 * Assumes the bench feeds it the port's clock-line drive and output level.
 */
`default_nettype none

module smbus_bus_peer (
    // Port side of the clock line.
    input wire logic dut_scl_oe,
    input wire logic dut_scl_out,
    // Resolved open-drain lines.
    output logic scl_line,
    output logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;

    logic scl_low = 1'b0;
    logic sda_low = 1'b0;

    // Pull-ups win unless a party pulls down; the peer's timed steps do not wait for a stretching port.
    assign scl_line = !((dut_scl_oe && !dut_scl_out) || scl_low);
    assign sda_line = !sda_low;

    // Data falls while the clock is high; works from idle and inside a frame.
    task automatic start_cond();
        sda_low = 1'b0;
        #24 scl_low = 1'b0;
        #24 sda_low = 1'b1;
        #24 scl_low = 1'b1;
    endtask : start_cond

    // One bit: data set while the clock is low, then one clock high phase.
    task automatic bit_cyc(input logic v);
        sda_low = !v;
        #24 scl_low = 1'b0;
        #24 scl_low = 1'b1;
    endtask : bit_cyc

    // Data rises while the clock is high; the clock then stands still high.
    task automatic stop_cond();
        scl_low = 1'b1;
        sda_low = 1'b1;
        #24 scl_low = 1'b0;
        #24 sda_low = 1'b0;
    endtask : stop_cond

endmodule : smbus_bus_peer

`default_nettype wire

// ### test/smbus_control_status_flags_tb.sv
/*
 * Self-checking bench for the control/status flag block: register-port
 * tasks, one-cycle engine events and a foreign bus party on the pins.
 * Assumes the flag block and package from src/ and the bus peer model.
 */
`default_nettype none

module smbus_control_status_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] CA = smbus_flags_pkg::CTL_ADDR;
    localparam logic [7:0] MA = smbus_flags_pkg::ADM_ADDR;
    localparam logic [3:0] PG = smbus_flags_pkg::REG_PAGE;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, dat_wr = 1'b0, master_cfg = 1'b0, ce = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, sfr_rdata;
    logic [3:0] sfr_page = 4'h0;
    logic start_req, stop_pend, go, ack_out, ack_auto, scl_out, scl_oe, scl_line, sda_line;
    smbus_flags_pkg::eng_ev_s eng_ev = '0;
    int err_count = 0;
    int checked = 0;

    // Free-running system clock, 5 ns period.
    always #2.5 clk_sys = ~clk_sys;

    smbus_ctrl_flags i_dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce),
        .SFR_ADDR(sfr_addr), .SFR_PAGE(sfr_page), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata),
        .SFR_BIT_WR(sfr_bit_wr), .SFR_BIT_ADDR(sfr_bit_addr), .SFR_BIT_VAL(sfr_bit_val),
        .SFR_RDATA(sfr_rdata), .DAT_WR(dat_wr), .MASTER_CFG(master_cfg), .ENG_EV(eng_ev),
        .START_REQ(start_req), .STOP_PEND(stop_pend), .GO(go), .ACK_OUT(ack_out), .ACK_AUTO(ack_auto),
        .SCL_IN(scl_line), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_line)
    );

    smbus_bus_peer i_peer (.dut_scl_oe(scl_oe), .dut_scl_out(scl_out), .scl_line(scl_line), .sda_line(sda_line));

    // Bench-driven inputs move 1 ns after the rising edge, clear of sampling; the peer's timed pin steps do not.
    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : tick

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_page = PG;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick();
        sfr_wr = 1'b0;
    endtask : wr

    task automatic wr_bit(input logic [2:0] b, input logic v);
        sfr_bit_addr = {smbus_flags_pkg::CTL_BIT_BASE, b};
        sfr_bit_val = v;
        sfr_bit_wr = 1'b1;
        tick();
        sfr_bit_wr = 1'b0;
    endtask : wr_bit

    // Read data is registered, so two edges pass before it is sampled.
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [3:0] p, input logic [7:0] exp);
        sfr_addr = a;
        sfr_page = p;
        tick(2);
        check(what, exp, sfr_rdata);
    endtask : rd_chk

    task automatic ctl(input logic [7:0] exp);
        rd_chk("control", CA, PG, exp);
    endtask : ctl

    // One-cycle engine pulse on top of the levels already standing.
    task automatic ev(input smbus_flags_pkg::eng_ev_s v);
        smbus_flags_pkg::eng_ev_s keep;
        keep = eng_ev;
        eng_ev = eng_ev | v;
        tick();
        eng_ev = keep;
    endtask : ev

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // Cuts a hang short.
    initial begin
        #200000;
        err_count++;
        $display("test watchdog expired");
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        check("scl_oe", 8'h00, {7'h00, scl_oe});
        ctl(8'h00);
        rd_chk("mask", MA, PG, 8'hFE);
        rd_chk("unmapped", 8'h55, PG, 8'h00);
        rd_chk("other page", CA, 4'h0, 8'h00);
        done("reset");
        // Read-only bits ignored, forced interrupt stretches the clock.
        wr(CA, 8'hFF);
        check("start_req", 8'h00, {7'h00, start_req});
        check("scl line", 8'h00, {7'h00, scl_line});
        ctl(8'h23);
        wr(CA, 8'h00);
        check("go", 8'h01, {7'h00, go});
        tick();
        check("go", 8'h00, {7'h00, go});
        ctl(8'h00);
        // A write while the clock enable is low must leave every flag frozen.
        ce = 1'b0;
        wr(CA, 8'h01);
        ce = 1'b1;
        ctl(8'h00);
        done("software");
        // Own START and a scheduled STOP.
        master_cfg = 1'b1;
        wr_bit(3'h5, 1'b1);
        check("start_req", 8'h01, {7'h00, start_req});
        ev('{start_gen: 1'b1, default: 1'b0});
        ctl(8'hE1);
        wr_bit(3'h4, 1'b1);
        check("stop_pend", 8'h01, {7'h00, stop_pend});
        ev('{stop_gen: 1'b1, default: 1'b0});
        ctl(8'h61);
        done("master");
        // Unrequested repeated START from the peer.
        ev('{start_gen: 1'b1, default: 1'b0});
        wr(CA, 8'h00);
        ctl(8'hC0);
        i_peer.start_cond();
        tick(8);
        ctl(8'h05);
        wr(CA, 8'h00);
        ctl(8'h00);
        // Data line low while the port sends a 1.
        ev('{start_gen: 1'b1, default: 1'b0});
        wr(CA, 8'h00);
        eng_ev.tx_bit_drive = 1'b1;
        eng_ev.tx_bit_val = 1'b1;
        i_peer.bit_cyc(1'b0);
        tick(8);
        ctl(8'h05);
        eng_ev = '0;
        wr(CA, 8'h00);
        // Clock line held low by the peer while generating.
        ev('{start_gen: 1'b1, default: 1'b0});
        wr(CA, 8'h00);
        eng_ev.gen_attempt = 1'b1;
        eng_ev.scl_released = 1'b1;
        tick(8);
        ctl(8'h05);
        eng_ev = '0;
        wr(CA, 8'h00);
        // Foreign STOP while master.
        ev('{start_gen: 1'b1, default: 1'b0});
        wr(CA, 8'h00);
        i_peer.stop_cond();
        tick(8);
        ctl(8'h15);
        wr(CA, 8'h00);
        done("arbitration");
        // Refused address, then an accepted one, data and STOP as slave.
        i_peer.start_cond();
        tick(8);
        ev('{addr_rx: 1'b1, addr_nack: 1'b1, default: 1'b0});
        tick();
        ev('{byte_rx: 1'b1, default: 1'b0});
        i_peer.stop_cond();
        tick(8);
        ctl(8'h00);
        i_peer.start_cond();
        tick(8);
        ev('{addr_rx: 1'b1, default: 1'b0});
        ctl(8'h21);
        wr(CA, 8'h00);
        ctl(8'h00);
        ev('{byte_rx: 1'b1, default: 1'b0});
        ctl(8'h09);
        ev('{ack_done: 1'b1, default: 1'b0});
        ctl(8'h01);
        wr(CA, 8'h00);
        i_peer.stop_cond();
        tick(8);
        ctl(8'h11);
        wr(CA, 8'h00);
        done("slave");
        // Transmit indicator, acknowledge capture, hardware acknowledge.
        i_peer.start_cond();
        tick(8);
        dat_wr = 1'b1;
        ev('{frame_start: 1'b1, default: 1'b0});
        dat_wr = 1'b0;
        ctl(8'h40);
        i_peer.sda_low = 1'b1;
        tick(8);
        ev('{ack_sample: 1'b1, byte_tx_ack: 1'b1, default: 1'b0});
        ctl(8'h43);
        i_peer.sda_low = 1'b0;
        tick(8);
        wr(CA, 8'h02);
        ev('{ack_sample: 1'b1, default: 1'b0});
        ctl(8'h40);
        ev('{frame_start: 1'b1, default: 1'b0});
        ctl(8'h00);
        wr(MA, 8'hFF);
        rd_chk("mask", MA, PG, 8'hFF);
        wr_bit(3'h1, 1'b1);
        check("ack_out", 8'h01, {7'h00, ack_out});
        check("ack_auto", 8'h01, {7'h00, ack_auto});
        ev('{byte_rx: 1'b1, default: 1'b0});
        ctl(8'h03);
        wr(CA, 8'h02);
        tick();
        // Clearing write and a hardware set in the same cycle.
        fork
            wr(CA, 8'h02);
            ev('{byte_rx: 1'b1, default: 1'b0});
        join
        check("go", 8'h00, {7'h00, go});
        ctl(8'h03);
        done("acknowledge");
        stop_test();
    end

endmodule : smbus_control_status_flags_tb

`default_nettype wire
